/* File: idpg_pkg.sv */
// Package for the identify parameter page: word map, constants, state type
// ======================================================================
// Overview of operation
// R1: Multiword DMA cycle time words read zero
// R2: Both minimum PIO cycle time words equal 0078h
// R3: Feature-support words hold 7028h, 500Ch, 4000h
// R4: Feature-enabled words hold 0001h, 0000h, 0000h
// R5: Advanced PCMCIA timing word reads 891Bh
// R6: Word zero carries the signature code
// R7: Default cylinders equal actual cylinder count
// R8: Sectors per card equal total sector count
// R9: Serial number right-aligned, space padded
// R10: ECC byte count word fixed at four
// R11: Model number left-aligned, space padded
// R12: Multiple word: 80h or 00h, max count
// R13: Capability bit 13 shows standby timer style
// R14: Bit 11 IORDY supported, bit 10 zero
// R15: Bit 9 reads one, bit 8 zero
// R16: PIO mode byte only 00h to 02h
// R17: Validity bit 0 always one
// R18: Validity bit 1 set, advanced fields valid
// R19: Current capacity equals cylinders*heads*sectors
// R20: Multiple setting: bits 15-9 zero, bit 8 one
// R21: LBA capacity reports total user sectors
// R22: Advanced PIO mask: bits 0,1 only
// R23: No-flow cycle time never below IORDY time
// R24: 256 words, reserved words read zero
package idpg_pkg;
   // ===================================================================
   // Page word indexes
   localparam logic [7:0] W_CONFIG = 8'h00;
   localparam logic [7:0] W_DEF_CYL = 8'h01;
   localparam logic [7:0] W_DEF_HEADS = 8'h03;
   localparam logic [7:0] W_OBS5 = 8'h05;
   localparam logic [7:0] W_DEF_SPT = 8'h06;
   localparam logic [7:0] W_CARD_MSW = 8'h07;
   localparam logic [7:0] W_CARD_LSW = 8'h08;
   localparam logic [7:0] W_SERIAL = 8'h0A;
   localparam logic [7:0] W_OBS20 = 8'h14;
   localparam logic [7:0] W_OBS21 = 8'h15;
   localparam logic [7:0] W_ECC = 8'h16;
   localparam logic [7:0] W_FW = 8'h17;
   localparam logic [7:0] W_MODEL = 8'h1B;
   localparam logic [7:0] W_MULT_MAX = 8'h2F;
   localparam logic [7:0] W_CAPS = 8'h31;
   localparam logic [7:0] W_PIO = 8'h33;
   localparam logic [7:0] W_VALID = 8'h35;
   localparam logic [7:0] W_CUR_CYL = 8'h36;
   localparam logic [7:0] W_CUR_HEADS = 8'h37;
   localparam logic [7:0] W_CUR_SPT = 8'h38;
   localparam logic [7:0] W_CAP_LSW = 8'h39;
   localparam logic [7:0] W_CAP_MSW = 8'h3A;
   localparam logic [7:0] W_MULT_SET = 8'h3B;
   localparam logic [7:0] W_LBA_LSW = 8'h3C;
   localparam logic [7:0] W_LBA_MSW = 8'h3D;
   localparam logic [7:0] W_ADV_PIO = 8'h40;
   localparam logic [7:0] W_DMA_MIN = 8'h41;
   localparam logic [7:0] W_DMA_REC = 8'h42;
   localparam logic [7:0] W_PIO_NOFC = 8'h43;
   localparam logic [7:0] W_PIO_IORDY = 8'h44;
   localparam logic [7:0] W_FEAT_SUP = 8'h52;
   localparam logic [7:0] W_FEAT_EN = 8'h55;
   localparam logic [7:0] W_POWER = 8'hA0;
   localparam logic [7:0] W_ADV_PCM = 8'hA4;
   localparam int SERIAL_WORDS = 10;
   localparam int FW_WORDS = 4;
   localparam int MODEL_WORDS = 20;
   // ===================================================================
   // Fixed word values
   localparam logic [15:0] V_OBS5 = 16'h0240;
   localparam logic [15:0] V_OBS20 = 16'h0002;
   localparam logic [15:0] V_ECC = 16'h0004;
   localparam logic [15:0] V_PIO_CYC = 16'h0078;
   localparam logic [15:0] V_FEAT_SUP0 = 16'h7028;
   localparam logic [15:0] V_FEAT_SUP1 = 16'h500C;
   localparam logic [15:0] V_FEAT_SUP2 = 16'h4000;
   localparam logic [15:0] V_FEAT_EN0 = 16'h0001;
   localparam logic [15:0] V_FEAT_EN1 = 16'h0000;
   localparam logic [15:0] V_FEAT_EN2 = 16'h0000;
   localparam logic [15:0] V_POWER = 16'h81F4;
   localparam logic [15:0] V_ADV_PCM = 16'h891B;
   localparam logic [15:0] V_ZERO = 16'h0000;
   localparam logic [7:0] V_MULT_REC = 8'h80;
   localparam logic [7:0] V_SPACE = 8'h20;
   localparam logic [7:0] V_PIO_MAX = 8'h02;
   // Capability and validity bit positions
   localparam int B_STANDBY = 13;
   localparam int B_IORDY = 11;
   localparam int B_IORDY_DIS = 10;
   localparam int B_LBA = 9;
   localparam int B_DMA = 8;
   localparam int B_GEOM_OK = 0;
   localparam int B_ADV_OK = 1;
   localparam int B_MSET_OK = 8;
   // ===================================================================
   // Control register offsets (bit 8 of the address selects them)
   localparam logic [8:0] R_DEF_CYL = 9'h100;
   localparam logic [8:0] R_DEF_HEADS = 9'h101;
   localparam logic [8:0] R_DEF_SPT = 9'h102;
   localparam logic [8:0] R_CUR_CYL = 9'h103;
   localparam logic [8:0] R_CUR_HEADS = 9'h104;
   localparam logic [8:0] R_CUR_SPT = 9'h105;
   localparam logic [8:0] R_TOTAL_LO = 9'h106;
   localparam logic [8:0] R_TOTAL_HI = 9'h107;
   localparam logic [8:0] R_MULT_MAX = 9'h108;
   localparam logic [8:0] R_MULT_CUR = 9'h109;
   localparam logic [8:0] R_CTRL = 9'h10A;
   localparam logic [8:0] R_PIO_MODE = 9'h10B;
   localparam logic [8:0] R_ADV_PIO = 9'h10C;
   localparam logic [8:0] R_STATUS = 9'h10D;
   // Control register fields and reset values
   localparam int C_STANDBY = 0;
   localparam int C_IORDY = 1;
   localparam int C_MULT_REC = 2;
   localparam logic [2:0] RST_CTRL = 3'h6;
   localparam logic [7:0] RST_MULT_MAX = 8'h01;
   localparam logic [1:0] RST_PIO = 2'h2;
   localparam logic [1:0] RST_ADV = 2'h3;
   // ===================================================================
   typedef struct packed {
      logic [15:0] def_cyl;
      logic [7:0] def_heads;
      logic [15:0] def_spt;
      logic [15:0] cur_cyl;
      logic [7:0] cur_heads;
      logic [15:0] cur_spt;
      logic [31:0] total;
      logic [7:0] mult_max;
      logic [7:0] mult_cur;
      logic [2:0] ctrl;
      logic [1:0] pio_mode;
      logic [1:0] adv_pio;
      logic [7:0] ptr;
      logic [15:0] rd_data;
      logic [15:0] id_word;
      logic id_valid;
   } idpg_state_s;
endpackage

/* File: idpg_page.sv */
// Identify parameter page: register port, page readout, stream port
`timescale 1ns/100ps
module idpg_page #(
   parameter logic [15:0] SIGNATURE = 16'h5A5A, // Arbitrary value
   parameter logic [159:0] SERIAL_TXT = "SN000001",
   parameter logic [63:0] FW_TXT = "REV1",
   parameter logic [319:0] MODEL_TXT = "FLASH STORAGE CARD"
) (
   input wire logic i_ref_clk, // 10 MHz core clock
   input wire logic i_sys_rst, // Synchronous reset, active high
   input wire logic [8:0] i_addr, // Register or page word address
   input wire logic [15:0] i_wr_data, // Write data
   input wire logic i_wr_en, // Write strobe
   input wire logic i_rd_en, // Read strobe
   output logic [15:0] o_rd_data, // Read data, cycle after strobe
   input wire logic i_id_restart, // Restart page stream at word 0
   input wire logic i_id_rd, // Take next page word
   output logic [15:0] o_id_word, // Streamed page word
   output logic o_id_valid // Streamed word valid, one cycle
);
   // ===================================================================
   // Text fields
   function automatic logic [319:0] space_fill(input logic [319:0] s);
      logic [319:0] t;
      t = s;
      for (int i = 0; i < 40; i++) begin
         if (t[i*8 +: 8] == 8'h00) begin
            t[i*8 +: 8] = idpg_pkg::V_SPACE;
         end
      end
      return t;
   endfunction

   function automatic logic [319:0] left_just(input logic [319:0] s);
      logic [319:0] t;
      t = s;
      for (int i = 0; i < 40; i++) begin
         if (t[319:312] == 8'h00 && t != '0) begin
            t = {t[311:0], 8'h00};
         end
      end
      return space_fill(t);
   endfunction

   // Text literals sit at the low end, so serial is right-aligned as is
   localparam logic [319:0] SER_ALL = space_fill({160'h0, SERIAL_TXT});
   localparam logic [159:0] SER_FLD = SER_ALL[159:0]; // R9
   localparam logic [319:0] MODEL_FLD = left_just(MODEL_TXT); // R11
   localparam logic [319:0] FW_ALL = left_just({FW_TXT, 256'h0});
   localparam logic [63:0] FW_FLD = FW_ALL[319:256];

   // ===================================================================
   // Page contents
   function automatic logic [31:0] cur_capacity(
      input idpg_pkg::idpg_state_s s);
      logic [39:0] p;
      p = 40'(s.cur_cyl) * 40'(s.cur_heads) * 40'(s.cur_spt);
      return p[31:0];
   endfunction

   function automatic logic [15:0] page_word(input logic [7:0] idx,
      input idpg_pkg::idpg_state_s s);
      logic [15:0] w;
      logic [31:0] cap;
      int k;
      w = idpg_pkg::V_ZERO; // R24
      cap = cur_capacity(s);
      k = 0;
      if (idx >= idpg_pkg::W_SERIAL &&
          idx < idpg_pkg::W_SERIAL + 8'(idpg_pkg::SERIAL_WORDS)) begin
         k = int'(idx - idpg_pkg::W_SERIAL);
         w = SER_FLD[159 - 16*k -: 16]; // R9
      end else if (idx >= idpg_pkg::W_FW &&
          idx < idpg_pkg::W_FW + 8'(idpg_pkg::FW_WORDS)) begin
         k = int'(idx - idpg_pkg::W_FW);
         w = FW_FLD[63 - 16*k -: 16];
      end else if (idx >= idpg_pkg::W_MODEL &&
          idx < idpg_pkg::W_MODEL + 8'(idpg_pkg::MODEL_WORDS)) begin
         k = int'(idx - idpg_pkg::W_MODEL);
         w = MODEL_FLD[319 - 16*k -: 16]; // R11
      end else begin
         unique case (idx)
            idpg_pkg::W_CONFIG: w = SIGNATURE; // R6
            idpg_pkg::W_DEF_CYL: w = s.def_cyl; // R7
            idpg_pkg::W_DEF_HEADS: w = {8'h00, s.def_heads};
            idpg_pkg::W_OBS5: w = idpg_pkg::V_OBS5;
            idpg_pkg::W_DEF_SPT: w = s.def_spt;
            idpg_pkg::W_CARD_MSW: w = s.total[31:16]; // R8
            idpg_pkg::W_CARD_LSW: w = s.total[15:0]; // R8
            idpg_pkg::W_OBS20: w = idpg_pkg::V_OBS20;
            idpg_pkg::W_OBS21: w = idpg_pkg::V_OBS20;
            idpg_pkg::W_ECC: w = idpg_pkg::V_ECC; // R10
            idpg_pkg::W_MULT_MAX: begin
               w[15:8] = s.ctrl[idpg_pkg::C_MULT_REC] ?
                  idpg_pkg::V_MULT_REC : 8'h00; // R12
               w[7:0] = s.mult_max; // R12
            end
            idpg_pkg::W_CAPS: begin
               w[idpg_pkg::B_STANDBY] = s.ctrl[idpg_pkg::C_STANDBY]; // R13
               w[idpg_pkg::B_IORDY] = s.ctrl[idpg_pkg::C_IORDY]; // R14
               w[idpg_pkg::B_IORDY_DIS] = 1'b0; // R14
               w[idpg_pkg::B_LBA] = 1'b1; // R15
               w[idpg_pkg::B_DMA] = 1'b0; // R15
            end
            idpg_pkg::W_PIO: w = {6'h00, s.pio_mode, 8'h00}; // R16
            idpg_pkg::W_VALID: begin
               w[idpg_pkg::B_GEOM_OK] = 1'b1; // R17
               w[idpg_pkg::B_ADV_OK] = 1'b1; // R18
            end
            idpg_pkg::W_CUR_CYL: w = s.cur_cyl;
            idpg_pkg::W_CUR_HEADS: w = {8'h00, s.cur_heads};
            idpg_pkg::W_CUR_SPT: w = s.cur_spt;
            idpg_pkg::W_CAP_LSW: w = cap[15:0]; // R19
            idpg_pkg::W_CAP_MSW: w = cap[31:16]; // R19
            idpg_pkg::W_MULT_SET: begin
               w[idpg_pkg::B_MSET_OK] = 1'b1; // R20
               w[7:0] = s.mult_cur; // R20
            end
            idpg_pkg::W_LBA_LSW: w = s.total[15:0]; // R21
            idpg_pkg::W_LBA_MSW: w = s.total[31:16]; // R21
            idpg_pkg::W_ADV_PIO: w = {14'h0000, s.adv_pio}; // R22
            idpg_pkg::W_DMA_MIN: w = idpg_pkg::V_ZERO; // R1
            idpg_pkg::W_DMA_REC: w = idpg_pkg::V_ZERO; // R1
            // Same figure in both keeps 67 never below 68
            idpg_pkg::W_PIO_NOFC: w = idpg_pkg::V_PIO_CYC; // R2 R23
            idpg_pkg::W_PIO_IORDY: w = idpg_pkg::V_PIO_CYC; // R2 R23
            idpg_pkg::W_FEAT_SUP: w = idpg_pkg::V_FEAT_SUP0; // R3
            idpg_pkg::W_FEAT_SUP + 8'h01: w = idpg_pkg::V_FEAT_SUP1; // R3
            idpg_pkg::W_FEAT_SUP + 8'h02: w = idpg_pkg::V_FEAT_SUP2; // R3
            idpg_pkg::W_FEAT_EN: w = idpg_pkg::V_FEAT_EN0; // R4
            idpg_pkg::W_FEAT_EN + 8'h01: w = idpg_pkg::V_FEAT_EN1; // R4
            idpg_pkg::W_FEAT_EN + 8'h02: w = idpg_pkg::V_FEAT_EN2; // R4
            idpg_pkg::W_POWER: w = idpg_pkg::V_POWER;
            idpg_pkg::W_ADV_PCM: w = idpg_pkg::V_ADV_PCM; // R5
            default: w = idpg_pkg::V_ZERO; // R24
         endcase
      end
      return w;
   endfunction

   // ===================================================================
   // Control register readback
   function automatic logic [15:0] reg_word(input logic [8:0] a,
      input idpg_pkg::idpg_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      unique case (a)
         idpg_pkg::R_DEF_CYL: w = s.def_cyl;
         idpg_pkg::R_DEF_HEADS: w = {8'h00, s.def_heads};
         idpg_pkg::R_DEF_SPT: w = s.def_spt;
         idpg_pkg::R_CUR_CYL: w = s.cur_cyl;
         idpg_pkg::R_CUR_HEADS: w = {8'h00, s.cur_heads};
         idpg_pkg::R_CUR_SPT: w = s.cur_spt;
         idpg_pkg::R_TOTAL_LO: w = s.total[15:0];
         idpg_pkg::R_TOTAL_HI: w = s.total[31:16];
         idpg_pkg::R_MULT_MAX: w = {8'h00, s.mult_max};
         idpg_pkg::R_MULT_CUR: w = {8'h00, s.mult_cur};
         idpg_pkg::R_CTRL: w = {13'h0000, s.ctrl};
         idpg_pkg::R_PIO_MODE: w = {14'h0000, s.pio_mode};
         idpg_pkg::R_ADV_PIO: w = {14'h0000, s.adv_pio};
         idpg_pkg::R_STATUS: w = {8'h00, s.ptr};
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   // ===================================================================
   // State
   idpg_pkg::idpg_state_s st_reg;
   idpg_pkg::idpg_state_s st_next;

   always_comb begin
      st_next = st_reg;
      st_next.rd_data = 16'h0000;
      st_next.id_valid = 1'b0;
      if (i_rd_en) begin
         st_next.rd_data = i_addr[8] ? reg_word(i_addr, st_reg)
                                     : page_word(i_addr[7:0], st_reg);
      end
      // Page words are read-only; writes there are dropped
      if (i_wr_en) begin
         unique case (i_addr)
            idpg_pkg::R_DEF_CYL: st_next.def_cyl = i_wr_data;
            idpg_pkg::R_DEF_HEADS: st_next.def_heads = i_wr_data[7:0];
            idpg_pkg::R_DEF_SPT: st_next.def_spt = i_wr_data;
            idpg_pkg::R_CUR_CYL: st_next.cur_cyl = i_wr_data;
            idpg_pkg::R_CUR_HEADS: st_next.cur_heads = i_wr_data[7:0];
            idpg_pkg::R_CUR_SPT: st_next.cur_spt = i_wr_data;
            idpg_pkg::R_TOTAL_LO: st_next.total[15:0] = i_wr_data;
            idpg_pkg::R_TOTAL_HI: st_next.total[31:16] = i_wr_data;
            idpg_pkg::R_MULT_MAX: st_next.mult_max = i_wr_data[7:0];
            idpg_pkg::R_MULT_CUR: st_next.mult_cur = i_wr_data[7:0];
            idpg_pkg::R_CTRL: st_next.ctrl = i_wr_data[2:0];
            idpg_pkg::R_PIO_MODE: begin
               // Reserved codes are never reported: clamp to mode 2
               st_next.pio_mode = (i_wr_data > 16'(idpg_pkg::V_PIO_MAX)) ?
                  idpg_pkg::V_PIO_MAX[1:0] : i_wr_data[1:0]; // R16
            end
            idpg_pkg::R_ADV_PIO: st_next.adv_pio = i_wr_data[1:0]; // R22
            default: st_next.def_cyl = st_reg.def_cyl;
         endcase
      end
      // Stream: restart wins over a fetch in the same cycle
      if (i_id_restart) begin
         st_next.ptr = 8'h00;
      end else if (i_id_rd) begin
         st_next.id_word = page_word(st_reg.ptr, st_reg); // R24
         st_next.id_valid = 1'b1;
         st_next.ptr = st_reg.ptr + 8'h01;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_reg <= '0;
         st_reg.mult_max <= idpg_pkg::RST_MULT_MAX;
         st_reg.ctrl <= idpg_pkg::RST_CTRL;
         st_reg.pio_mode <= idpg_pkg::RST_PIO;
         st_reg.adv_pio <= idpg_pkg::RST_ADV;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rd_data = st_reg.rd_data;
   assign o_id_word = st_reg.id_word;
   assign o_id_valid = st_reg.id_valid;

   // ===================================================================
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   dma_zero_a: assert property ( // R1
      (i_rd_en && (i_addr == 9'h041 || i_addr == 9'h042))
      |=> o_rd_data == 16'h0000)
      else $error("Multiword DMA cycle word not zero");
   pio_cycle_a: assert property ( // R2
      (i_rd_en && (i_addr == 9'h043 || i_addr == 9'h044))
      |=> o_rd_data == 16'h0078)
      else $error("PIO cycle time word wrong");
   feat_sup_a: assert property ( // R3
      (i_rd_en && i_addr == 9'h053)
      |=> o_rd_data == 16'h500C)
      else $error("Feature support word wrong");
   feat_en_a: assert property ( // R4
      (i_rd_en && i_addr == 9'h055)
      |=> o_rd_data == 16'h0001)
      else $error("Feature enabled word wrong");
   adv_pcm_a: assert property ( // R5
      (i_rd_en && i_addr == 9'h0A4)
      |=> o_rd_data == 16'h891B)
      else $error("Advanced timing word wrong");
   caps_bits_a: assert property ( // R15
      (i_rd_en && i_addr == 9'h031)
      |=> o_rd_data[10:8] == 3'b010)
      else $error("Capability bits 10..8 wrong");
   pio_mode_a: assert property ( // R16
      (i_rd_en && i_addr == 9'h033)
      |=> o_rd_data[15:8] <= 8'h02 && o_rd_data[7:0] == 8'h00)
      else $error("PIO mode byte reserved");
   // Product worked out here, independent of the readout function
   cap_prod_a: assert property ( // R19
      (i_rd_en && i_addr == 9'h039)
      |=> o_rd_data == 16'($past(st_reg.cur_cyl) *
         $past(st_reg.cur_heads) * $past(st_reg.cur_spt)))
      else $error("Current capacity low word wrong");
   mult_set_a: assert property ( // R20
      (i_rd_en && i_addr == 9'h03B)
      |=> o_rd_data == {8'h01, $past(st_reg.mult_cur)})
      else $error("Multiple setting word wrong");
   valid_bits_a: assert property ( // R17
      (i_rd_en && i_addr == 9'h035)
      |=> o_rd_data == 16'h0003)
      else $error("Validity word wrong");
   reserved_a: assert property ( // R24
      (i_rd_en && i_addr == 9'h0B0)
      |=> o_rd_data == 16'h0000)
      else $error("Reserved word not zero");
   stream_a: assert property ( // R24
      (i_id_rd && !i_id_restart)
      |=> o_id_valid && st_reg.ptr == $past(st_reg.ptr) + 8'h01
      ##1 (!o_id_valid || $past(i_id_rd)))
      else $error("Stream step wrong");

   rd_cap_c: cover property (i_rd_en && i_addr == 9'h03A);
   wr_clamp_c: cover property (i_wr_en && i_addr == idpg_pkg::R_PIO_MODE
      && i_wr_data > 16'h0002);
   stream_wrap_c: cover property (i_id_rd && st_reg.ptr == 8'hFF);
   rd_serial_c: cover property (i_rd_en && i_addr == 9'h013);
endmodule // idpg_page

/* File: idpg_host.sv */
// Host reader model: fetches the identify page word by word
`timescale 1ns/100ps
module idpg_host (
   input wire logic i_ref_clk, // Core clock
   input wire logic i_start, // Begin one page read
   input wire logic i_slow, // Idle cycle after each fetch
   input wire logic [15:0] i_id_word, // Streamed word
   input wire logic i_id_valid, // Word valid pulse
   output logic o_id_restart, // Pointer restart pulse
   output logic o_id_rd, // Fetch strobe
   output logic o_busy // Page read in progress
);
   logic [15:0] page [256];
   int got;
   initial begin
      o_id_restart = 1'b0;
      o_id_rd = 1'b0;
      o_busy = 1'b0;
      got = 0;
   end
   // ==================================================================
   // Capture in arrival order, word 0 first
   always @(posedge i_ref_clk) begin
      if (i_id_valid === 1'b1) begin
         page[got % 256] = i_id_word;
         got = got + 1;
      end
   end
   // Fetch sequence; slow mode proves valid is tied to each fetch
   always @(posedge i_ref_clk) begin
      if (i_start === 1'b1 && !o_busy) begin
         o_busy <= 1'b1;
         o_id_restart <= 1'b1;
         got = 0;
         @(posedge i_ref_clk);
         o_id_restart <= 1'b0;
         for (int n = 0; n < 256; n++) begin
            o_id_rd <= 1'b1;
            @(posedge i_ref_clk);
            if (i_slow) begin
               o_id_rd <= 1'b0;
               @(posedge i_ref_clk);
            end
         end
         o_id_rd <= 1'b0;
         repeat (2) @(posedge i_ref_clk);
         o_busy <= 1'b0;
      end
   end
endmodule // idpg_host

/* File: idpg_page_tb.sv */
// Testbench for the identify parameter page
`timescale 1ns/100ps
module idpg_page_tb;
   localparam logic [15:0] SIG = 16'h1357; // Arbitrary signature value
   logic ref_clk, sys_rst, wr_en, rd_en, start, slow, restart, id_rd, busy;
   logic id_valid;
   logic [8:0] addr;
   logic [15:0] wdata, rdata, id_word;
   logic [15:0] dcyl, dspt, ccyl, cspt;
   logic [7:0] dhd, chd, mmax, mcur;
   logic [31:0] tot;
   logic [2:0] ctl;
   logic [1:0] pio, adv;
   int failures, checks;
   idpg_page #(.SIGNATURE(SIG), .SERIAL_TXT("SN01"), .FW_TXT("REV1ABCD"),
      .MODEL_TXT("CARD")) idpg_page_i (.i_ref_clk(ref_clk),
      .i_sys_rst(sys_rst), .i_addr(addr), .i_wr_data(wdata),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata),
      .i_id_restart(restart), .i_id_rd(id_rd), .o_id_word(id_word),
      .o_id_valid(id_valid));
   idpg_host idpg_host_i (.i_ref_clk(ref_clk), .i_start(start),
      .i_slow(slow), .i_id_word(id_word), .i_id_valid(id_valid),
      .o_id_restart(restart), .o_id_rd(id_rd), .o_busy(busy));
   // ==================================================================
   // Checking and bus tasks
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   // Read data stands one cycle only, so the next cycle must be zero
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(negedge ref_clk);
      chk($sformatf("reg_%h", a), e, rdata);
      @(negedge ref_clk);
      chk("rd_idle", 16'h0000, rdata);
   endtask
   function automatic logic [15:0] exp_word(input int n);
      logic [31:0] cap;
      cap = 32'(ccyl) * 32'(chd) * 32'(cspt);
      case (n)
         0: return SIG;
         1: return dcyl;
         3: return {8'h00, dhd};
         5: return 16'h0240;
         6: return dspt;
         7: return tot[31:16];
         8: return tot[15:0];
         18: return 16'h534E;
         19: return 16'h3031;
         20, 21: return 16'h0002;
         22: return 16'h0004;
         23: return 16'h5245;
         24: return 16'h5631;
         25: return 16'h4142;
         26: return 16'h4344;
         27: return 16'h4341;
         28: return 16'h5244;
         47: return {ctl[2] ? 8'h80 : 8'h00, mmax};
         49: return {2'b00, ctl[0], 1'b0, ctl[1], 11'h200};
         51: return {6'h00, pio, 8'h00};
         53: return 16'h0003;
         54: return ccyl;
         55: return {8'h00, chd};
         56: return cspt;
         57: return cap[15:0];
         58: return cap[31:16];
         59: return {8'h01, mcur};
         60: return tot[15:0];
         61: return tot[31:16];
         64: return {14'h0000, adv};
         67, 68: return 16'h0078;
         82: return 16'h7028;
         83: return 16'h500C;
         84: return 16'h4000;
         85: return 16'h0001;
         160: return 16'h81F4;
         164: return 16'h891B;
         default: return (n inside {[10:17], [29:46]}) ? 16'h2020 : 16'h0000;
      endcase
   endfunction
   // Full page through the host model, bounded wait
   task automatic page_read(input logic s);
      int k;
      @(posedge ref_clk);
      slow <= s;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      // Busy rises only after the host has seen start
      @(posedge ref_clk);
      for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge ref_clk);
      if (k == 2000) begin
         failures++;
         finish_test();
      end
      chk("word_count", 16'h0100, 16'(idpg_host_i.got));
      for (int n = 0; n < 256; n++)
         chk($sformatf("word_%0d", n), exp_word(n),
            idpg_host_i.page[n]);
      chk("nofc_ge_iordy", 16'h0001,
         16'(idpg_host_i.page[67] >= idpg_host_i.page[68]));
      rd(9'h10D, 16'h0000);
   endtask
   // ==================================================================
   // Scenarios
   task automatic t_reset_regs();
      for (int a = 0; a < 16; a++)
         rd(9'h100 + 9'(a), a == 8 ? 16'h0001 : a == 10 ? 16'h0006 :
            a == 11 ? 16'h0002 : a == 12 ? 16'h0003 : 16'h0000);
   endtask
   task automatic t_geometry();
      dcyl = 16'h03C5; dhd = 8'h10; dspt = 16'h0020;
      ccyl = 16'h1234; chd = 8'h0F; cspt = 16'h003F;
      tot = 32'h0012_3456; mmax = 8'h10; mcur = 8'h08;
      wr(9'h100, dcyl);
      wr(9'h101, {8'h00, dhd});
      wr(9'h102, dspt);
      wr(9'h103, ccyl);
      wr(9'h104, {8'h00, chd});
      wr(9'h105, cspt);
      wr(9'h106, tot[15:0]);
      wr(9'h107, tot[31:16]);
      wr(9'h108, {8'h00, mmax});
      wr(9'h109, {8'h00, mcur});
      page_read(1'b0);
   endtask
   // Reserved PIO codes are never shown; clamped to mode 2
   task automatic t_modes();
      wr(9'h10B, 16'h0005);
      rd(9'h10B, 16'h0002);
      ctl = 3'h1; pio = 2'h1; adv = 2'h0;
      wr(9'h10A, {13'h0000, ctl});
      wr(9'h10B, {14'h0000, pio});
      wr(9'h10C, {14'h0000, adv});
      page_read(1'b1);
   endtask
   task automatic t_bus();
      int bw[12] = '{19, 49, 51, 53, 57, 58, 59, 67, 68, 83, 85, 176};
      // Page words read over the register port as well as the stream
      foreach (bw[i])
         rd(9'(bw[i]), exp_word(bw[i]));
      wr(9'h041, 16'hFFFF);
      rd(9'h041, 16'h0000);
      rd(9'h0A4, 16'h891B);
      rd(9'h052, 16'h7028);
      rd(9'h000, SIG);
      wr(9'h10F, 16'hFFFF);
      rd(9'h10F, 16'h0000);
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      ctl = 3'h6; pio = 2'h2; adv = 2'h3;
   endtask
   // ==================================================================
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      sys_rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; start = 1'b0;
      slow = 1'b0; addr = 9'h000; wdata = 16'h0000;
      failures = 0; checks = 0;
      do_reset();
      t_reset_regs();
      t_geometry();
      t_modes();
      t_bus();
      do_reset();
      t_reset_regs();
      finish_test();
   end
endmodule // idpg_page_tb
